// File: siom_defs.svh
// register offsets, reset values, field positions and mode masks
`ifndef SIOM_DEFS_SVH
`define SIOM_DEFS_SVH

// byte offsets of the register words on the bus
`define SIOM_OFS_IN_POL_A 8'h00
`define SIOM_OFS_IN_POL_B 8'h04
`define SIOM_OFS_IN_POL_C 8'h08
`define SIOM_OFS_OUT_ALLOC_A 8'h0C
`define SIOM_OFS_OUT_ALLOC_B 8'h10
`define SIOM_OFS_OUT_ALLOC_C 8'h14
`define SIOM_OFS_OUT_ALLOC_D 8'h18
`define SIOM_OFS_IN_ALLOC_A 8'h1C
`define SIOM_OFS_IN_ALLOC_B 8'h20
`define SIOM_OFS_CTRL_MODE 8'h24
`define SIOM_OFS_STATUS 8'h28

// reset values; output words carry the shipped pin allocation
`define SIOM_RST_IN_POL 16'h0000
`define SIOM_RST_OUT_ALLOC_A 16'h2114
`define SIOM_RST_OUT_ALLOC_B 16'h0003
`define SIOM_RST_OUT_ALLOC_C 16'h0005
`define SIOM_RST_OUT_ALLOC_D 16'h0000
`define SIOM_RST_IN_ALLOC_A 16'h3210
`define SIOM_RST_IN_ALLOC_B 16'h7654
`define SIOM_RST_CTRL_MODE 4'h0

// built-in input allocation: function n on pin n+1
`define SIOM_DFLT_IN_ALLOC 32'h7654_3210

// field positions inside the third polarity word
`define SIOM_POL_C_PIN9 0
`define SIOM_POL_C_PIN10 4
`define SIOM_POL_C_USER 12

// selector codes
`define SIOM_IN_SEL_LAST_PIN 4'h9
`define SIOM_IN_SEL_ALWAYS_ON 4'hA
`define SIOM_OUT_SEL_LAST_PIN 4'h5

// modes (one bit per mode code) supporting position or velocity functions
`define SIOM_POS_MODES 16'h7D92
`define SIOM_VEL_MODES 16'h53FD

// sizes
`define SIOM_NUM_IN_PINS 10
`define SIOM_NUM_IN_FUNCS 8
`define SIOM_NUM_OUT_PINS 5
`define SIOM_NUM_OUT_FUNCS 15

`endif

// File: siom_pkg.sv
// types shared by the servo i/o map
package siom_pkg;

  // one hex digit of a parameter word
  typedef logic [3:0] siom_digit_t;

  // how a status function depends on the control mode
  typedef enum logic [2:0] {
    SIOM_SUP_ALWAYS = 3'b001,
    SIOM_SUP_POS = 3'b010,
    SIOM_SUP_VEL = 3'b100
  } siom_support_t;

  // status function order, which is also the selector digit order
  typedef enum int {
    SIOM_FN_FAULT = 0,
    SIOM_FN_IN_POSITION = 1,
    SIOM_FN_SPEED_REACHED = 2,
    SIOM_FN_MOTION_DETECT = 3,
    SIOM_FN_DRIVE_READY = 4,
    SIOM_FN_SERVO_READY = 5,
    SIOM_FN_TORQUE_LIMITED = 6,
    SIOM_FN_SPEED_LIMITED = 7,
    SIOM_FN_BRAKE_CTRL = 8,
    SIOM_FN_WARNING = 9,
    SIOM_FN_POS_NEAR = 10,
    SIOM_FN_PULSE_RATIO_SEL = 11,
    SIOM_FN_POS_TRIGGER = 12,
    SIOM_FN_EXT_DYN_BRAKE = 13,
    SIOM_FN_HOMING_DONE = 14
  } siom_fn_t;

endpackage : siom_pkg

// File: siom_sync2.sv
// two-flop synchroniser for the input pins
`timescale 1ns/100ps
module siom_sync2
  import siom_pkg::*;
#(
  parameter int WIDTH = 10
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  // first stage is read by the second stage only
  logic [WIDTH-1:0] meta_r;

  genvar b;
  generate
    for (b = 0; b < WIDTH; b = b + 1)
    begin : g_bit
      // each pin gets its own pair of flops
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_r[b] <= 1'b0;
          syncOut[b] <= 1'b0;
        end
        else
        begin
          meta_r[b] <= asyncIn[b];
          syncOut[b] <= meta_r[b];
        end
      end
    end
  endgenerate

endmodule : siom_sync2

// File: siom_io_map.sv
// servo drive i/o polarity and output pin map with wishbone registers
//
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
`include "siom_defs.svh"
module siom_io_map
  import siom_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // connector side
  input wire logic [9:0] inputPins,
  output logic [4:0] outputPins,
  // drive side
  input wire logic [14:0] statusFunc,
  output logic [7:0] inputFunc
);

  // parameter words
  logic [15:0] inPolA_r; // polarity of pins 1-4
  logic [15:0] inPolB_r; // polarity of pins 5-8
  logic [15:0] inPolC_r; // pins 9-10 and allocation select
  logic [15:0] outAllocA_r; // output selectors, group a
  logic [15:0] outAllocB_r; // output selectors, group b
  logic [15:0] outAllocC_r; // output selectors, group c
  logic [15:0] outAllocD_r; // output selectors, group d
  logic [15:0] inAllocA_r; // input selectors, functions 0-3
  logic [15:0] inAllocB_r; // input selectors, functions 4-7
  logic [3:0] ctrlMode_r; // control mode digit

  // bus handshake
  logic ack_r;
  logic [31:0] rdData_r;
  logic [31:0] rdData_nxt;
  logic busReq; // request present and not yet acknowledged
  logic wrStrobe; // write takes effect at this edge

  // pin side
  logic [9:0] pinSync; // pins after two flops
  logic [9:0] pinPol; // per-pin polarity bit
  logic [9:0] pinLevel; // pins after polarity
  logic [31:0] inSelAll; // selectors for all input functions
  logic [7:0] inputFunc_nxt;
  logic [63:0] outSelAll; // all output selectors
  logic [14:0] fnSupported; // function allowed in current mode
  logic [4:0] pinHits [0:14]; // per-function one-hot pin route
  logic [4:0] outputPins_nxt;
  logic posMode; // current mode runs position functions
  logic velMode; // current mode runs velocity functions

  // pins arrive from outside the clock domain
  siom_sync2 #(
    .WIDTH(`SIOM_NUM_IN_PINS)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .asyncIn(inputPins),
    .syncOut(pinSync)
  );

  // the ack flop makes every answer take exactly one cycle
  assign busReq = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wrStrobe = busReq & wb_we_i;

  // bus acknowledge: one cycle after the request, dropped the next
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= busReq;
    end
  end

  // read mux; unmapped offsets answer with zero
  always_comb
  begin
    rdData_nxt = 32'h0000_0000;
    case (wb_adr_i)
      `SIOM_OFS_IN_POL_A:
        rdData_nxt = {16'h0000, inPolA_r};
      `SIOM_OFS_IN_POL_B:
        rdData_nxt = {16'h0000, inPolB_r};
      `SIOM_OFS_IN_POL_C:
        rdData_nxt = {16'h0000, inPolC_r};
      `SIOM_OFS_OUT_ALLOC_A:
        rdData_nxt = {16'h0000, outAllocA_r};
      `SIOM_OFS_OUT_ALLOC_B:
        rdData_nxt = {16'h0000, outAllocB_r};
      `SIOM_OFS_OUT_ALLOC_C:
        rdData_nxt = {16'h0000, outAllocC_r};
      `SIOM_OFS_OUT_ALLOC_D:
        rdData_nxt = {16'h0000, outAllocD_r};
      `SIOM_OFS_IN_ALLOC_A:
        rdData_nxt = {16'h0000, inAllocA_r};
      `SIOM_OFS_IN_ALLOC_B:
        rdData_nxt = {16'h0000, inAllocB_r};
      `SIOM_OFS_CTRL_MODE:
        rdData_nxt = {28'h000_0000, ctrlMode_r};
      // live state: synced pins, decoded functions, output pins
      `SIOM_OFS_STATUS:
        rdData_nxt = {9'h000, outputPins, inputFunc, pinSync};
      default:
        rdData_nxt = 32'h0000_0000;
    endcase
  end

  // read data is latched with the request so it stands with ack
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdData_r <= 32'h0000_0000;
    end
    else if (busReq)
    begin
      rdData_r <= rdData_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdData_r;

  // polarity words; byte lanes 0 and 1 carry the 16-bit value
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      inPolA_r <= `SIOM_RST_IN_POL;
      inPolB_r <= `SIOM_RST_IN_POL;
      inPolC_r <= `SIOM_RST_IN_POL;
    end
    else if (wrStrobe)
    begin
      if (wb_adr_i == `SIOM_OFS_IN_POL_A)
      begin
        if (wb_sel_i[0]) inPolA_r[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) inPolA_r[15:8] <= wb_dat_i[15:8];
      end
      if (wb_adr_i == `SIOM_OFS_IN_POL_B)
      begin
        if (wb_sel_i[0]) inPolB_r[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) inPolB_r[15:8] <= wb_dat_i[15:8];
      end
      if (wb_adr_i == `SIOM_OFS_IN_POL_C)
      begin
        if (wb_sel_i[0]) inPolC_r[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) inPolC_r[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // output allocation words; reset gives the shipped pin map
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      outAllocA_r <= `SIOM_RST_OUT_ALLOC_A;
      outAllocB_r <= `SIOM_RST_OUT_ALLOC_B;
      outAllocC_r <= `SIOM_RST_OUT_ALLOC_C;
      outAllocD_r <= `SIOM_RST_OUT_ALLOC_D;
    end
    else if (wrStrobe)
    begin
      if (wb_adr_i == `SIOM_OFS_OUT_ALLOC_A)
      begin
        if (wb_sel_i[0]) outAllocA_r[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) outAllocA_r[15:8] <= wb_dat_i[15:8];
      end
      if (wb_adr_i == `SIOM_OFS_OUT_ALLOC_B)
      begin
        if (wb_sel_i[0]) outAllocB_r[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) outAllocB_r[15:8] <= wb_dat_i[15:8];
      end
      if (wb_adr_i == `SIOM_OFS_OUT_ALLOC_C)
      begin
        if (wb_sel_i[0]) outAllocC_r[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) outAllocC_r[15:8] <= wb_dat_i[15:8];
      end
      if (wb_adr_i == `SIOM_OFS_OUT_ALLOC_D)
      begin
        if (wb_sel_i[0]) outAllocD_r[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) outAllocD_r[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // user input allocation and control mode
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      inAllocA_r <= `SIOM_RST_IN_ALLOC_A;
      inAllocB_r <= `SIOM_RST_IN_ALLOC_B;
      ctrlMode_r <= `SIOM_RST_CTRL_MODE;
    end
    else if (wrStrobe)
    begin
      if (wb_adr_i == `SIOM_OFS_IN_ALLOC_A)
      begin
        if (wb_sel_i[0]) inAllocA_r[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) inAllocA_r[15:8] <= wb_dat_i[15:8];
      end
      if (wb_adr_i == `SIOM_OFS_IN_ALLOC_B)
      begin
        if (wb_sel_i[0]) inAllocB_r[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1]) inAllocB_r[15:8] <= wb_dat_i[15:8];
      end
      if ((wb_adr_i == `SIOM_OFS_CTRL_MODE) && wb_sel_i[0])
      begin
        ctrlMode_r <= wb_dat_i[3:0];
      end
    end
  end

  // gather one polarity bit per pin, low digit of each word first
  assign pinPol[0] = inPolA_r[0];
  assign pinPol[1] = inPolA_r[4];
  assign pinPol[2] = inPolA_r[8];
  assign pinPol[3] = inPolA_r[12];
  assign pinPol[4] = inPolB_r[0];
  assign pinPol[5] = inPolB_r[4];
  assign pinPol[6] = inPolB_r[8];
  assign pinPol[7] = inPolB_r[12];
  assign pinPol[8] = inPolC_r[`SIOM_POL_C_PIN9];
  assign pinPol[9] = inPolC_r[`SIOM_POL_C_PIN10];

  // only bit 0 of a digit is used; other digit values act by their low bit
  // inversion happens ahead of the function decode
  assign pinLevel = pinSync ^ pinPol;

  // user allocation only when the top digit reads exactly 1
  assign inSelAll = (inPolC_r[15:12] == 4'h1) ?
                    {inAllocB_r, inAllocA_r} :
                    `SIOM_DFLT_IN_ALLOC;

  genvar f;
  generate
    // one selector per input function
    for (f = 0; f < `SIOM_NUM_IN_FUNCS; f = f + 1)
    begin : g_infn
      siom_digit_t sel;
      assign sel = inSelAll[4*f +: 4];
      // pins 1-10, then forced on, anything above forced off
      always_comb
      begin
        if (sel <= `SIOM_IN_SEL_LAST_PIN)
          inputFunc_nxt[f] = pinLevel[sel];
        else if (sel == `SIOM_IN_SEL_ALWAYS_ON)
          inputFunc_nxt[f] = 1'b1;
        else
          inputFunc_nxt[f] = 1'b0;
      end
    end
  endgenerate

  // decoded input functions are registered
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      inputFunc <= 8'h00;
    end
    else
    begin
      inputFunc <= inputFunc_nxt;
    end
  end

  // mode classes from one bit per mode code
  assign posMode = |(`SIOM_POS_MODES & (16'h0001 << ctrlMode_r));
  assign velMode = |(`SIOM_VEL_MODES & (16'h0001 << ctrlMode_r));

  // output selectors; digit 1 of word d is skipped
  assign outSelAll = {4'h0, outAllocD_r[15:12], outAllocD_r[11:8],
                      outAllocD_r[3:0], outAllocC_r,
                      outAllocB_r, outAllocA_r};

  // support class per function
  function automatic siom_support_t fn_support(input int idx);
    siom_support_t s;
    s = SIOM_SUP_ALWAYS;
    case (idx)
      SIOM_FN_IN_POSITION,
      SIOM_FN_POS_NEAR,
      SIOM_FN_PULSE_RATIO_SEL,
      SIOM_FN_POS_TRIGGER,
      SIOM_FN_HOMING_DONE:
        s = SIOM_SUP_POS;
      SIOM_FN_SPEED_REACHED:
        s = SIOM_SUP_VEL;
      default:
        s = SIOM_SUP_ALWAYS;
    endcase
    return s;
  endfunction : fn_support

  generate
    // one route per status function
    for (f = 0; f < `SIOM_NUM_OUT_FUNCS; f = f + 1)
    begin : g_outfn
      siom_digit_t sel;
      logic gated;
      assign sel = outSelAll[4*f +: 4];
      // unsupported functions are held off whatever the selector
      always_comb
      begin
        case (fn_support(f))
          SIOM_SUP_POS: fnSupported[f] = posMode;
          SIOM_SUP_VEL: fnSupported[f] = velMode;
          SIOM_SUP_ALWAYS: fnSupported[f] = 1'b1;
          default: fnSupported[f] = 1'b0;
        endcase
      end
      assign gated = statusFunc[f] & fnSupported[f];
      // 0 and codes above 5 route nowhere
      always_comb
      begin
        pinHits[f] = 5'b0_0000;
        if ((sel != 4'h0) && (sel <= `SIOM_OUT_SEL_LAST_PIN))
          pinHits[f] = gated ? (5'b0_0001 << (sel - 4'h1)) :
                       5'b0_0000;
      end
    end
  endgenerate

  // several functions on one pin are ored together
  always_comb
  begin
    outputPins_nxt = 5'b0_0000;
    for (int i = 0; i < `SIOM_NUM_OUT_FUNCS; i++)
    begin
      outputPins_nxt = outputPins_nxt | pinHits[i];
    end
  end

  // output pins come straight from flops
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      outputPins <= 5'b0_0000;
    end
    else
    begin
      outputPins <= outputPins_nxt;
    end
  end

endmodule : siom_io_map

// File: siom_io_map_assertions.sv
// port-level assertions for the servo i/o map
`timescale 1ns/100ps
`include "siom_defs.svh"
module siom_io_map_assertions
  import siom_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [9:0] inputPins,
  input wire logic [4:0] outputPins,
  input wire logic [14:0] statusFunc,
  input wire logic [7:0] inputFunc
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  localparam logic [15:0] POS_M = `SIOM_POS_MODES;
  localparam logic [15:0] VEL_M = `SIOM_VEL_MODES;
  logic [2:0] upCnt_r; // edges since reset, saturates so sync is full
  logic [3:0] mode_r; // shadow of the control mode word
  logic [14:0] gateM; // status bits the current mode forces off
  assign gateM = (POS_M[mode_r] ? 15'h0000 : 15'h5c02)
    | (VEL_M[mode_r] ? 15'h0000 : 15'h0004);
  // settle counter and mode snoop, taken on the same edge as the design
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      upCnt_r <= 3'h0;
    else if (upCnt_r != 3'h7)
      upCnt_r <= upCnt_r + 3'h1;
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      mode_r <= 4'h0;
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
      && wb_adr_i == `SIOM_OFS_CTRL_MODE && wb_sel_i[0])
      mode_r <= wb_dat_i[3:0];
  sequence bus_take_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // two quiet edges: no register can be changing under the outputs
  sequence quiet_s;
    (upCnt_r == 3'h7 && !wb_cyc_i)[*2];
  endsequence
  ack_answer_a: assert property (bus_take_s |=> wb_ack_o)
    else $error("no ack one cycle after a request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");
  dat_hold_a: assert property (!(wb_cyc_i && wb_stb_i && !wb_ack_o)
    |=> $stable(wb_dat_o)) else $error("read data moved between requests");
  rd_upper_a: assert property (wb_ack_o && !$past(wb_we_i)
    && $past(wb_adr_i) != `SIOM_OFS_STATUS |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  in_hold_a: assert property ((upCnt_r == 3'h7 && !wb_cyc_i
    && $stable(inputPins))[*4] |=> $stable(inputFunc))
    else $error("input function moved with pins steady");
  out_hold_a: assert property (quiet_s ##0 $stable(statusFunc)
    |=> $stable(outputPins)) else $error("output pins moved alone");
  mode_gate_a: assert property (quiet_s ##0 $stable(statusFunc & ~gateM)
    |=> $stable(outputPins)) else $error("unsupported function reached pin");
endmodule : siom_io_map_assertions
bind siom_io_map siom_io_map_assertions chk_u (.clk_sys(clk_sys),
  .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .inputPins(inputPins), .outputPins(outputPins),
  .statusFunc(statusFunc), .inputFunc(inputFunc));

// File: siom_plc_model.sv
// connector-side controller model: drives inputs, watches outputs
`timescale 1ns/100ps
module siom_plc_model
(
  input wire logic clk_sys,
  input wire logic [9:0] pinReq,
  input wire logic slow,
  input wire logic [4:0] outputPins,
  output logic [9:0] inputPins,
  output logic [4:0] outSeen
);
  logic [9:0] hold_r; // request parked for the slow path
  // a slow controller lags one extra scan, so the sync sees late edges
  always @(posedge clk_sys)
  begin
    hold_r <= pinReq;
    inputPins <= slow ? hold_r : pinReq;
    outSeen <= outputPins;
  end
endmodule : siom_plc_model

// File: tb.sv
// self-checking bench for the servo i/o map
`timescale 1ns/100ps
`include "siom_defs.svh"
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb
  import siom_pkg::*;
;
  logic clk_sys = 1'b0; // 4 ns system clock
  logic rst_n = 1'b0; // active low reset
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck, slow = 1'b0;
  logic [7:0] wbAdr = 8'h00, inFunc;
  logic [3:0] wbSel = 4'h3; // both used byte lanes
  logic [31:0] wbDat = 32'h0000_0000, wbDatO;
  logic [9:0] pinReq = 10'h000, pins;
  logic [4:0] outPins, outSeen;
  logic [14:0] status = 15'h0000; // drive status functions
  logic [15:0] rg [0:9]; // register shadow, index is offset over four
  int fails = 0, nCompared = 0, seed = 32'h2d0a;
  always #2 clk_sys = ~clk_sys;
  siom_io_map dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .inputPins(pins), .outputPins(outPins), .statusFunc(status),
    .inputFunc(inFunc));
  siom_plc_model plc_u (.clk_sys(clk_sys), .pinReq(pinReq), .slow(slow),
    .outputPins(outPins), .inputPins(pins), .outSeen(outSeen));
  // expected pins: route each supported function by its selector digit
  function automatic logic [4:0] expOut(input logic [14:0] st);
    logic [4:0] o;
    logic [3:0] s;
    logic [15:0] pm, vm;
    o = 5'h00;
    pm = `SIOM_POS_MODES;
    vm = `SIOM_VEL_MODES;
    for (int f = 0; f < 15; f++)
    begin
      s = f < 12 ? rg[3 + f / 4][4 * (f % 4) +: 4]
        : rg[6][4 * (f == 12 ? 0 : f - 11) +: 4];
      if ((f == 1 || f > 9 && f != 13) && !pm[rg[9][3:0]])
        s = 4'h0;
      if (f == 2 && !vm[rg[9][3:0]])
        s = 4'h0;
      if (s >= 4'h1 && s <= 4'h5)
        o[s - 4'h1] |= st[f];
    end
    return o;
  endfunction : expOut
  // expected input functions: polarity first, then the selector
  function automatic logic [7:0] expIn(input logic [9:0] p);
    logic [9:0] e;
    logic [31:0] al;
    logic [3:0] s;
    logic [7:0] r;
    for (int i = 0; i < 10; i++)
      e[i] = p[i] ^ (i < 8 ? rg[i / 4][4 * (i % 4)]
        : rg[2][4 * (i - 8)]);
    al = rg[2][15:12] == 4'h1 ? {rg[8], rg[7]} : `SIOM_DFLT_IN_ALLOC;
    for (int f = 0; f < 8; f++)
    begin
      s = al[4 * f +: 4];
      r[f] = s <= 4'h9 ? e[s] : s == 4'hA;
    end
    return r;
  endfunction : expIn
  // one classic cycle; the request stands until ack is seen
  task automatic wbx(input logic w, input logic [7:0] a,
    input logic [15:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDat <= {16'h0000, d};
    // look at ack only on rising edges, as the slave samples
    @(posedge clk_sys);
    while (wbAck !== 1'b1 && n < 50)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (wbAck !== 1'b1)
    begin
      fails++;
      $display("[ERR] %0t no bus answer", $time);
      completeRun();
    end
    // data is taken and the request released at the ack edge
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (w && a <= `SIOM_OFS_CTRL_MODE && a[1:0] == 2'b00)
      rg[a >> 2] = a == `SIOM_OFS_CTRL_MODE ? {12'h000, d[3:0]} : d;
  endtask : wbx
  // shadow of every word as reset leaves it
  task automatic loadDefaults();
    rg = '{`SIOM_RST_IN_POL, `SIOM_RST_IN_POL, `SIOM_RST_IN_POL,
      `SIOM_RST_OUT_ALLOC_A, `SIOM_RST_OUT_ALLOC_B, `SIOM_RST_OUT_ALLOC_C,
      `SIOM_RST_OUT_ALLOC_D, `SIOM_RST_IN_ALLOC_A, `SIOM_RST_IN_ALLOC_B,
      {12'h000, `SIOM_RST_CTRL_MODE}};
  endtask : loadDefaults
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wbx(1'b0, a, 16'h0000, q);
    `CHK(q, e)
  endtask : rdChk
  // let n edges pass, then look where everything has landed
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle
  task automatic completeRun();
    $display("compared %0d failed %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : completeRun
  initial
  begin
    logic [31:0] q;
    int r, x;
    loadDefaults();
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++)
      rdChk(8'(4 * i), {16'h0000, rg[i]});
    wbx(1'b1, 8'h2c, 16'hffff, q);
    rdChk(8'h2c, 32'h0000_0000);
    status <= 15'h7fff;
    // control modes 0 to 14 with the shipped allocation
    for (int m = 0; m < 15; m++)
    begin
      wbx(1'b1, `SIOM_OFS_CTRL_MODE, 16'(m), q);
      settle(2);
      `CHK(outPins, expOut(status))
    end
    $display("test defaults done");
    // mode f forbids every gated function; toggling them moves no pin
    wbx(1'b1, `SIOM_OFS_CTRL_MODE, 16'h000f, q);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk_sys);
      status <= status ^ 15'h5c06;
      settle(2);
      `CHK(outPins, expOut(15'h7fff))
    end
    $display("test mode gate done");
    // random words, pins and status; mode and user select included
    for (int k = 0; k < 300; k++)
    begin
      r = $random(seed);
      x = (r & 15) % 10;
      if (x == 2)
        r[15:12] = {3'b000, r[15]};
      wbx(1'b1, 8'(4 * x), r[15:0], q);
      @(posedge clk_sys);
      pinReq <= 10'($random(seed));
      status <= 15'($random(seed));
      slow <= r[20];
      settle(6);
      `CHK(outPins, expOut(status))
      `CHK(outSeen, expOut(status))
      `CHK(inFunc, expIn(pinReq))
      rdChk(`SIOM_OFS_STATUS, {9'h000, expOut(status),
        expIn(pinReq), pinReq});
      rdChk(8'(4 * x), {16'h0000, rg[x]});
    end
    $display("test random done");
    // reset in mid-run: outputs drop, shipped words come back
    @(posedge clk_sys);
    rst_n <= 1'b0;
    settle(2);
    `CHK(outPins, 5'h00)
    `CHK(inFunc, 8'h00)
    loadDefaults();
    @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++)
      rdChk(8'(4 * i), {16'h0000, rg[i]});
    settle(6);
    `CHK(outPins, expOut(status))
    `CHK(inFunc, expIn(pinReq))
    $display("test reset done");
    completeRun();
  end
  // about 5200 cycles are needed; this cuts a hang at 50000
  initial
  begin
    #200000;
    fails++;
    completeRun();
  end
endmodule : tb
